//--- hdl/adc_sequencer_error_flags.sv
// Purpose: error flag register and halt logic of a command-list converter sequencer
// Assumes: event inputs are single-cycle pulses from logic on clk_i
// Notes:   soft reset bit self-clears; severe flags halt until soft reset
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Contract
// - any severe flag set stops all converter operation.
// - soft reset needed to resume; it clears the four severe flags.
// - restart and load-ok flags never halt the converter.
// - restart and load-ok flags clear by writing one, or soft reset.
// - all flags held cleared while converter enable is zero.
// - writing zero keeps flags; writing one never sets; severe flags unwritable.
// - bit 7 set on illegal result store or command fetch outside memory.
// - bit 6 set on reserved command bits or reserved resolution encoding.
// - bit 5 set when executing list lacks an end-of-list command.
// - restart mode: trigger after abort without restart, or during restart load.
// - trigger mode: trigger before initial restart sets trigger-overlap.
// - trigger before current sequence finished sets trigger-overlap.
// - trigger while previous trigger starts sampling sets trigger-overlap.
// - trigger mode: automatic trigger coinciding with external trigger sets it.
// - bit 2 set on restart after trigger before list end or abort.
// - restart request overrun does not set restart-request flag.
// - bit 1 set in restart mode on restart without list load-ok.
// - no load-ok flag when abort pending or abort coincides with restart.
// - no load-ok flag on first restart after enable, stop, soft reset, single buffer.
// - trigger mode: restart automatically sets the trigger control bit.
// - each flag requests interrupt only when its enable bit is one.
module adc_sequencer_error_flags (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // sequencer events, one-cycle pulses, and status levels
  input  wire logic        store_illegal_i,
  input  wire logic        fetch_illegal_i,
  input  wire logic        cmd_reserved_i,
  input  wire logic        cmd_bad_resolution_i,
  input  wire logic        list_end_missing_i,
  input  wire logic        trigger_i,
  input  wire logic        restart_i,
  input  wire logic        restart_overrun_i,
  input  wire logic        abort_req_i,
  input  wire logic        sequence_abort_pending_i,
  input  wire logic        list_load_ok_bit_i,
  input  wire logic        restart_load_done_i,
  input  wire logic        sequence_done_i,
  input  wire logic        first_cmd_sampling_i,
  input  wire logic        list_end_reached_i,
  input  wire logic        stop_exit_i,
  // status to the sequencer
  output logic             converter_run_o,
  output logic             trigger_control_bit_o,
  output logic             soft_reset_o,
  output logic             irq_o
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  irq_en;
    logic [7:0]  ctrl;
    logic        ack;
    logic [31:0] rdata;
    logic        aborted;     // abort seen, no restart since
    logic        restart_ld;  // restart loading first command
    logic        started;     // initial restart issued
    logic        seq_active;  // trigger taken, list not finished
    logic        first_rst;   // next restart is first since enable/sr/stop
    logic        trigger_control_bit_ctl;
    logic        run;
    logic        irq;
  } state_s;

  state_s q, d;

  logic        wr, rd_en;
  logic        en, sr, trigger_control_bit_mode;
  logic        ext_trigger_control_bit, any_trigger_control_bit;
  logic [7:0]  set_v, clr_v;

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    d = q;
    wr = cyc_i && stb_i && !q.ack && we_i && sel_i[0];
    rd_en = cyc_i && stb_i && !q.ack;
    en = q.ctrl[err_flags_pkg::CTRL_EN_BIT];
    sr = q.ctrl[err_flags_pkg::CTRL_SR_BIT];
    trigger_control_bit_mode = q.ctrl[err_flags_pkg::CTRL_TRIGMODE_BIT];
    ext_trigger_control_bit = trigger_i && q.run;
    // restart in trigger mode raises an automatic trigger
    any_trigger_control_bit = ext_trigger_control_bit || (trigger_control_bit_mode && restart_i && q.run);
    set_v = 8'h00;
    clr_v = 8'h00;

    // bus slave, registered ack one cycle after the request
    d.ack = rd_en;
    d.rdata = 32'h0000_0000;
    if (rd_en && !we_i)
    begin
      case (adr_i)
        err_flags_pkg::ERR_FLAGS_ADDR:  d.rdata = {24'h00_0000, q.flags};
        err_flags_pkg::ERR_IRQ_EN_ADDR: d.rdata = {24'h00_0000, q.irq_en};
        err_flags_pkg::CTRL_ADDR:       d.rdata = {24'h00_0000, q.ctrl};
        default:                        d.rdata = 32'h0000_0000;
      endcase
    end
    // soft reset bit self-clears after one cycle
    d.ctrl[err_flags_pkg::CTRL_SR_BIT] = 1'b0;
    if (wr && adr_i == err_flags_pkg::CTRL_ADDR)
    begin
      d.ctrl = dat_i[7:0] & err_flags_pkg::CTRL_MASK;
    end
    if (wr && adr_i == err_flags_pkg::ERR_IRQ_EN_ADDR)
    begin
      d.irq_en = dat_i[7:0] & (err_flags_pkg::SEVERE_MASK | err_flags_pkg::MINOR_MASK);
    end
    if (wr && adr_i == err_flags_pkg::ERR_FLAGS_ADDR)
    begin
      clr_v = dat_i[7:0] & err_flags_pkg::MINOR_MASK;
    end

    // error detection, only while running
    if (q.run)
    begin
      set_v[err_flags_pkg::IA_BIT] = store_illegal_i || fetch_illegal_i;
      set_v[err_flags_pkg::CMD_BIT] = cmd_reserved_i || cmd_bad_resolution_i;
      set_v[err_flags_pkg::EOL_BIT] = list_end_missing_i;
      set_v[err_flags_pkg::TRIGGER_CONTROL_BIT_BIT] =
          (!trigger_control_bit_mode && ext_trigger_control_bit && (q.aborted || q.restart_ld))
        || (trigger_control_bit_mode && ext_trigger_control_bit && !q.started && !restart_i)
        || (ext_trigger_control_bit && q.seq_active)
        || (ext_trigger_control_bit && first_cmd_sampling_i)
        || (trigger_control_bit_mode && ext_trigger_control_bit && restart_i);
      set_v[err_flags_pkg::RSTAR_BIT] = restart_i && q.seq_active
        && !list_end_reached_i && !abort_req_i
        && !q.aborted && !restart_overrun_i;
      set_v[err_flags_pkg::LIST_LOAD_OK_BIT_BIT] = !trigger_control_bit_mode && restart_i && !list_load_ok_bit_i
        && !sequence_abort_pending_i && !abort_req_i
        && !q.first_rst && !q.ctrl[err_flags_pkg::CTRL_SINGLEBUF_BIT];
    end

    // flow tracking for overlap detection
    if (abort_req_i)
    begin
      d.aborted = 1'b1;
      d.seq_active = 1'b0;
    end
    if (sequence_done_i || list_end_reached_i)
    begin
      d.seq_active = 1'b0;
    end
    if (restart_i && q.run)
    begin
      d.aborted = 1'b0;
      d.restart_ld = 1'b1;
      d.started = 1'b1;
      d.first_rst = 1'b0;
      d.seq_active = 1'b0;
    end
    if (restart_load_done_i)
    begin
      d.restart_ld = 1'b0;
    end
    if (any_trigger_control_bit && !set_v[err_flags_pkg::TRIGGER_CONTROL_BIT_BIT])
    begin
      d.seq_active = 1'b1;
    end
    d.trigger_control_bit_ctl = trigger_control_bit_mode && restart_i && q.run;
    if (stop_exit_i)
    begin
      d.first_rst = 1'b1;
    end

    // set beats a simultaneous write-one clear
    d.flags = ((q.flags & ~clr_v) | set_v)
            & (err_flags_pkg::SEVERE_MASK | err_flags_pkg::MINOR_MASK);
    if (sr)
    begin
      d.flags = err_flags_pkg::FLAGS_RESET;
      d.aborted = 1'b0;
      d.restart_ld = 1'b0;
      d.started = 1'b0;
      d.seq_active = 1'b0;
      d.first_rst = 1'b1;
    end
    if (!en)
    begin
      d.flags = err_flags_pkg::FLAGS_RESET;
      d.aborted = 1'b0;
      d.restart_ld = 1'b0;
      d.started = 1'b0;
      d.seq_active = 1'b0;
      d.first_rst = 1'b1;
    end

    // minor flags deliberately left out of the halt term
    d.run = en && !sr && ((d.flags & err_flags_pkg::SEVERE_MASK) == 8'h00);
    d.irq = (d.flags & d.irq_en) != 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign dat_o = q.rdata;
  assign ack_o = q.ack;
  assign converter_run_o = q.run;
  assign trigger_control_bit_o = q.trigger_control_bit_ctl;
  assign soft_reset_o = q.ctrl[err_flags_pkg::CTRL_SR_BIT];
  assign irq_o = q.irq;

endmodule // adc_sequencer_error_flags

//--- hdl/err_flags_pkg.sv
// Purpose: constants for the converter error flag block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   flag register sits in low byte of its word
package err_flags_pkg;

  localparam int unsigned ADDR_W = 8;

  // register byte addresses
  localparam logic [7:0] ERR_FLAGS_ADDR = 8'h08;
  localparam logic [7:0] ERR_IRQ_EN_ADDR = 8'h06;
  localparam logic [7:0] CTRL_ADDR = 8'h00;

  // error flag bit positions
  localparam int unsigned IA_BIT = 7;
  localparam int unsigned CMD_BIT = 6;
  localparam int unsigned EOL_BIT = 5;
  localparam int unsigned TRIGGER_CONTROL_BIT_BIT = 3;
  localparam int unsigned RSTAR_BIT = 2;
  localparam int unsigned LIST_LOAD_OK_BIT_BIT = 1;

  // control register bit positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_SR_BIT = 1;
  localparam int unsigned CTRL_TRIGMODE_BIT = 2;
  localparam int unsigned CTRL_STRSEQA_BIT = 3;
  localparam int unsigned CTRL_SINGLEBUF_BIT = 4;

  // masks
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] SEVERE_MASK = 8'hE8;
  localparam logic [7:0] MINOR_MASK = 8'h06;
  localparam logic [7:0] CTRL_MASK = 8'h1F;
  localparam logic [7:0] CTRL_RESET = 8'h00;

endpackage

//--- sim/adc_sequencer_error_flags_properties.sv
// Purpose: port checks on the error flag block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every instance of the block
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module err_flags_checker (
  // clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  // events and status
  input wire logic        store_illegal_i,
  input wire logic        cmd_reserved_i,
  input wire logic        fetch_illegal_i,
  input wire logic        cmd_bad_resolution_i,
  input wire logic        list_end_missing_i,
  input wire logic        restart_i,
  input wire logic        soft_reset_o,
  input wire logic        converter_run_o,
  input wire logic        trigger_control_bit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a bus access may carry a soft reset, so keep it out
  sequence quiet_run_s;
    converter_run_o && !(cyc_i && stb_i);
  endsequence
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  a_ack_next: assert property (req_s |=> ack_o) else $error("ack missing");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0) else $error("stray data");
  a_halt_access: assert property (quiet_run_s ##0 store_illegal_i |=> !converter_run_o)
    else $error("no halt on access error");
  a_halt_cmd: assert property (quiet_run_s ##0 cmd_reserved_i |=> !converter_run_o)
    else $error("no halt on command error");
  a_halt_eol: assert property (quiet_run_s ##0 list_end_missing_i |=> !converter_run_o)
    else $error("no halt on list end error");
  a_sr_pulse: assert property (soft_reset_o |=> !soft_reset_o) else $error("reset held");
  a_auto_trigger_control_bit: assert property (trigger_control_bit_o |-> $past(restart_i) && $past(converter_run_o))
    else $error("trigger bit without restart");
  a_halt_fetch: assert property (quiet_run_s ##0 fetch_illegal_i |=> !converter_run_o)
    else $error("no halt on fetch error");
  a_halt_res: assert property (quiet_run_s ##0 cmd_bad_resolution_i |=> !converter_run_o)
    else $error("no halt on resolution error");
  a_sr_halt: assert property (soft_reset_o |=> !converter_run_o)
    else $error("run during soft reset");
endmodule // err_flags_checker

bind adc_sequencer_error_flags err_flags_checker err_flags_checker_inst (.clk_i, .rst_i,
  .cyc_i, .stb_i, .ack_o, .dat_o, .store_illegal_i, .cmd_reserved_i, .list_end_missing_i,
  .fetch_illegal_i, .cmd_bad_resolution_i,
  .restart_i, .soft_reset_o, .converter_run_o, .trigger_control_bit_o);

//--- sim/seq_event_model.sv
// Purpose: sequencer side that raises event pulses
// Assumes: bench toggles a request bit per event
// Notes:   toggles keep back-to-back events apart
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module seq_event_model (
  // clock and requests
  input  wire logic        clk_i,
  input  wire logic [11:0] req_i,
  // one-cycle event pulses
  output logic      [11:0] pulse_o
);
  logic [11:0] last_q;
  always_ff @(posedge clk_i)
  begin
    last_q  <= req_i;
    pulse_o <= req_i ^ last_q;
  end
endmodule // seq_event_model

//--- sim/tb_adc_sequencer_error_flags.sv
// Purpose: bench for the converter error flag block
// Assumes: bus answers one cycle after a request
// Notes:   events arrive through the partner model
`timescale 1ns/1ns
module tb_adc_sequencer_error_flags;
  localparam logic [7:0] fa = err_flags_pkg::ERR_FLAGS_ADDR;
  localparam logic [7:0] ca = err_flags_pkg::CTRL_ADDR;
  logic        clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, q, e, dat_o;
  logic [11:0] req = 12'h000, p;
  logic [3:0]  lv = 4'h0;
  logic        ack, run, irq;
  int          n_fail = 0, n_compared = 0, cyc_n = 0;
  always #5 clk_i = ~clk_i;
  seq_event_model seq_event_model_inst (.clk_i(clk_i), .req_i(req), .pulse_o(p));
  adc_sequencer_error_flags adc_sequencer_error_flags_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack), .store_illegal_i(p[0]), .fetch_illegal_i(p[1]),
    .cmd_reserved_i(p[2]), .cmd_bad_resolution_i(p[3]), .list_end_missing_i(p[4]),
    .trigger_i(p[5]), .restart_i(p[6]), .abort_req_i(p[7]), .restart_load_done_i(p[8]),
    .sequence_done_i(p[9]), .list_end_reached_i(p[10]), .stop_exit_i(p[11]),
    .restart_overrun_i(lv[0]), .sequence_abort_pending_i(lv[1]),
    .list_load_ok_bit_i(lv[2]), .first_cmd_sampling_i(lv[3]), .converter_run_o(run),
    .trigger_control_bit_o(), .soft_reset_o(), .irq_o(irq));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    do @(posedge clk_i); while (ack !== 1'h1);
    q = dat_o;
    {cyc, stb} <= 2'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    wb(a, 1'h0, 32'h0);
    chk(q, x);
  endtask
  // toggles, so pulses never merge
  task automatic ev(input logic [11:0] m);
    @(posedge clk_i);
    req <= req ^ m;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    rc(fa, 32'h0);
    rc(8'h10, 32'h0);
    wb(err_flags_pkg::ERR_IRQ_EN_ADDR, 1'h1, 32'hE8);
    wb(ca, 1'h1, 32'h03);
    for (int i = 0; i < 5; i++)
    begin
      e = i < 2 ? 32'h80 : i < 4 ? 32'h40 : 32'h20;
      ev(12'h001 << i);
      rc(fa, e);
      chk(32'(run), 32'h0);
      chk(32'(irq), 32'h1);
      wb(fa, 1'h1, 32'hFF);
      rc(fa, e);
      wb(ca, 1'h1, 32'h03);
      rc(fa, 32'h0);
      chk(32'(run), 32'h1);
    end
    wb(ca, 1'h1, 32'h07);
    ev(12'h020);
    rc(fa, 32'h08);
    wb(ca, 1'h1, 32'h07);
    ev(12'h060);
    wb(fa, 1'h0, 32'h0);
    chk(q & 32'h08, 32'h08);
    wb(ca, 1'h1, 32'h03);
    ev(12'h040);
    rc(fa, 32'h0);
    ev(12'h040);
    rc(fa, 32'h02);
    chk(32'(run), 32'h1);
    chk(32'(irq), 32'h0);
    wb(fa, 1'h1, 32'h00);
    rc(fa, 32'h02);
    wb(fa, 1'h1, 32'h02);
    rc(fa, 32'h0);
    lv <= 4'h2;
    ev(12'h040);
    rc(fa, 32'h0);
    lv <= 4'h0;
    ev(12'h800);
    ev(12'h040);
    rc(fa, 32'h0);
    for (int ov = 1; ov >= 0; ov--)
    begin
      wb(ca, 1'h1, 32'h03);
      lv <= 4'h4;
      ev(12'h040);
      ev(12'h100);
      ev(12'h020);
      lv <= ov ? 4'h5 : 4'h4;
      ev(12'h040);
      rc(fa, ov ? 32'h0 : 32'h04);
    end
    wb(ca, 1'h1, 32'h00);
    rc(fa, 32'h0);
    wb(ca, 1'h1, 32'h03);
    lv <= 4'h0;
    ev(12'h040);
    ev(12'h020);
    rc(fa, 32'h08);
    wb(ca, 1'h1, 32'h03);
    lv <= 4'h4;
    ev(12'h040);
    ev(12'h100);
    ev(12'h080);
    ev(12'h020);
    rc(fa, 32'h08);
    // clean pass through a list, then a restart at its end
    wb(ca, 1'h1, 32'h03);
    ev(12'h040);
    ev(12'h100);
    ev(12'h020);
    ev(12'h200);
    ev(12'h020);
    ev(12'h440);
    rc(fa, 32'h0);
    lv <= 4'h0;
    ev(12'h0C0);
    rc(fa, 32'h0);
    ev(12'h100);
    lv <= 4'h8;
    ev(12'h020);
    rc(fa, 32'h08);
    wb(ca, 1'h1, 32'h03);
    lv <= 4'h4;
    ev(12'h040);
    ev(12'h100);
    ev(12'h020);
    ev(12'h020);
    rc(fa, 32'h08);
    wb(ca, 1'h1, 32'h13);
    lv <= 4'h0;
    ev(12'h040);
    ev(12'h040);
    rc(fa, 32'h0);
    tally_and_finish;
  end
  // whole run takes well under a thousand cycles
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 3000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end
endmodule // tb_adc_sequencer_error_flags
